// [design/modbus_register_remap.sv]
`timescale 1ns/1ps
`default_nettype none
module modbus_register_remap #(
    parameter int SUP_TIMEOUT_CYCLES = remap_pkg::SUP_CYCLES
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    input  wire logic                     i_cfg_wr,
    input  wire remap_pkg::cfg_entry_type i_cfg_entry,
    input  wire logic                     i_cfg_sup_enable,
    input  wire logic                     i_cfg_done,
    input  wire logic                     i_commit,
    input  wire logic                     i_req,
    input  wire remap_pkg::access_type    i_req_access,
    input  wire logic                     i_nat_ack,
    input  wire logic [15:0]              i_nat_rdata,
    input  wire logic                     i_conn_open,
    input  wire logic                     i_conn_close,
    output logic                          o_ready,
    output logic                          o_rsp_valid,
    output logic [15:0]                   o_rsp_data,
    output logic                          o_nat_req,
    output remap_pkg::access_type         o_nat_access,
    output logic                          o_sup_timeout,
    output logic                          o_reset_request
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    remap_pkg::state_type state_r;
    logic [15:0]          table_r [remap_pkg::ALIAS_COUNT];
    logic                 sup_enable_r;
    logic [31:0]          gap_count_r;
    logic                 conn_open_r;
    logic                 seen_conn_r;

    logic        is_alias;
    logic [5:0]  alias_index;
    logic [15:0] alias_offset;
    logic [15:0] target;
    logic        take_req;
    logic        unassigned;
    logic        nat_done;
    logic        cfg_index_ok;
    logic        gap_running;
    logic        gap_expired;

    // ----------------------------------------
    // alias decode
    // ----------------------------------------
    always_comb begin
        is_alias     = (i_req_access.reg_num >= remap_pkg::ALIAS_FIRST) &&
                       (i_req_access.reg_num <= remap_pkg::ALIAS_LAST);
        alias_offset = i_req_access.reg_num - remap_pkg::ALIAS_FIRST;
        alias_index  = alias_offset[5:0];
        target       = is_alias ? table_r[alias_index] : remap_pkg::NO_TARGET;
    end

    // ----------------------------------------
    // request classification
    // ----------------------------------------
    always_comb begin
        unassigned   = is_alias && (target == remap_pkg::NO_TARGET);
        take_req     = (state_r == remap_pkg::ST_IDLE) && i_req;
        nat_done     = (state_r == remap_pkg::ST_NATIVE) && i_nat_ack;
        cfg_index_ok = i_cfg_entry.index <= remap_pkg::LAST_INDEX;
    end

    // ----------------------------------------
    // boot-time table load
    // ----------------------------------------
    generate
        for (genvar g = 0; g < remap_pkg::ALIAS_COUNT; g++) begin : g_entry
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    table_r[g] <= remap_pkg::NO_TARGET;
                end else if (state_r == remap_pkg::ST_BOOT && i_cfg_wr && cfg_index_ok &&
                             i_cfg_entry.index == 6'(g)) begin
                    table_r[g] <= i_cfg_entry.target;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sup_enable_r <= 1'b0;
        end else if (state_r == remap_pkg::ST_BOOT && i_cfg_done) begin
            sup_enable_r <= i_cfg_sup_enable;
        end
    end

    // ----------------------------------------
    // commit forces a reset
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_reset_request <= 1'b0;
        end else if (i_commit) begin
            o_reset_request <= 1'b1;
        end
    end

    // ----------------------------------------
    // request sequencing
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= remap_pkg::ST_BOOT;
        end else begin
            unique case (state_r)
                remap_pkg::ST_BOOT: begin
                    if (i_cfg_done) begin
                        state_r <= remap_pkg::ST_IDLE;
                    end
                end
                remap_pkg::ST_IDLE: begin
                    if (i_req && !unassigned) begin
                        state_r <= remap_pkg::ST_NATIVE;
                    end
                end
                remap_pkg::ST_NATIVE: begin
                    if (i_nat_ack) begin
                        state_r <= remap_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // ready towards the master
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_ready <= 1'b0;
        end else if (state_r == remap_pkg::ST_BOOT && i_cfg_done) begin
            o_ready <= 1'b1;
        end else if (take_req && !unassigned) begin
            o_ready <= 1'b0;
        end else if (nat_done) begin
            o_ready <= 1'b1;
        end
    end

    // ----------------------------------------
    // answer to the master
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rsp_valid <= 1'b0;
            o_rsp_data  <= remap_pkg::ZERO_DATA;
        end else if (take_req && unassigned) begin
            o_rsp_valid <= 1'b1;
            o_rsp_data  <= remap_pkg::ZERO_DATA;
        end else if (nat_done) begin
            o_rsp_valid <= 1'b1;
            o_rsp_data  <= o_nat_access.write ? remap_pkg::ZERO_DATA
                           : i_nat_rdata;
        end else begin
            o_rsp_valid <= 1'b0;
        end
    end

    // ----------------------------------------
    // native-side request
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_nat_req    <= 1'b0;
            o_nat_access <= '0;
        end else if (take_req && !unassigned) begin
            o_nat_req            <= 1'b1;
            o_nat_access.write   <= i_req_access.write;
            o_nat_access.data    <= i_req_access.data;
            o_nat_access.reg_num <= is_alias ? target
                                    : i_req_access.reg_num;
        end else if (nat_done) begin
            o_nat_req <= 1'b0;
        end
    end

    // ----------------------------------------
    // supervisory timer between connections
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            conn_open_r <= 1'b0;
            seen_conn_r <= 1'b0;
        end else if (i_conn_open) begin
            conn_open_r <= 1'b1;
            seen_conn_r <= 1'b1;
        end else if (i_conn_close) begin
            conn_open_r <= 1'b0;
        end
    end

    always_comb begin
        gap_running = sup_enable_r && seen_conn_r && !conn_open_r;
        gap_expired = gap_running &&
                      (gap_count_r == 32'(SUP_TIMEOUT_CYCLES) - 32'h00000001);
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || !gap_running || i_conn_open) begin
            gap_count_r <= 32'h00000000;
        end else if (gap_count_r < 32'(SUP_TIMEOUT_CYCLES)) begin
            gap_count_r <= gap_count_r + 32'h00000001;
        end
    end

    // ----------------------------------------
    // timeout flag, set wins over clear
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_sup_timeout <= 1'b0;
        end else if (gap_expired) begin
            o_sup_timeout <= 1'b1;
        end else if (i_conn_open) begin
            o_sup_timeout <= 1'b0;
        end
    end

endmodule : modbus_register_remap
`default_nettype wire

// [design/remap_pkg.sv]
package remap_pkg;

    // ----------------------------------------
    // alias window
    // ----------------------------------------
    localparam int          ALIAS_COUNT = 50;
    localparam logic [15:0] ALIAS_FIRST = 16'h1389;
    localparam logic [15:0] ALIAS_LAST  = 16'h13BA;
    localparam logic [15:0] NO_TARGET   = 16'h0000;
    localparam logic [15:0] ZERO_DATA   = 16'h0000;
    localparam logic [5:0]  LAST_INDEX  = 6'h31;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ         = 25_000_000;
    localparam int SUP_TIMEOUT_MS = 1000;
    localparam int SUP_CYCLES     = SUP_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int RESTART_WAIT_S = 30;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic        write;
        logic [15:0] reg_num;
        logic [15:0] data;
    } access_type;

    typedef struct packed {
        logic [5:0]  index;
        logic [15:0] target;
    } cfg_entry_type;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_IDLE,
        ST_NATIVE
    } state_type;

endpackage : remap_pkg

// [tb/remap_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module remap_asserts #(parameter int SUP_TIMEOUT_CYCLES = 20) (
    input wire logic i_clk, i_reset, i_commit, i_req, i_nat_ack, i_conn_open, i_conn_close,
    input wire logic o_ready, o_rsp_valid, o_nat_req, o_sup_timeout, o_reset_request,
    input wire logic [15:0] i_nat_rdata, o_rsp_data,
    input wire remap_pkg::access_type i_req_access, o_nat_access);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire logic h = i_req_access.reg_num inside {[remap_pkg::ALIAS_FIRST:remap_pkg::ALIAS_LAST]};
    sequence s_al; i_req && o_ready && h; endsequence
    sequence s_nt; i_req && o_ready && !h; endsequence
    property p_cm; i_commit |=> o_reset_request; endproperty
    a_cm: assert property (p_cm) else $error("commit lost");
    property p_st; o_reset_request |=> o_reset_request; endproperty
    a_st: assert property (p_st) else $error("reset request dropped");
    property p_hd; o_nat_req && !i_nat_ack |=> o_nat_req && $stable(o_nat_access); endproperty
    a_hd: assert property (p_hd) else $error("native request moved");
    property p_an; o_nat_req && i_nat_ack |=> o_rsp_valid
        && o_rsp_data == ($past(o_nat_access.write) ? 16'h0000 : $past(i_nat_rdata)); endproperty
    a_an: assert property (p_an) else $error("bad answer");
    property p_nt; s_nt |=> o_nat_req && o_nat_access == $past(i_req_access); endproperty
    a_nt: assert property (p_nt) else $error("native number altered");
    property p_al; s_al |=> o_rsp_valid && o_rsp_data == 16'h0000 && !o_nat_req
        || o_nat_req && o_nat_access.write == $past(i_req_access.write); endproperty
    a_al: assert property (p_al) else $error("alias misrouted");
    property p_bz; o_nat_req |-> !o_ready; endproperty
    a_bz: assert property (p_bz) else $error("ready while busy");
    property p_gp; i_conn_open ##1 !i_conn_close [*2] |-> !$rose(o_sup_timeout); endproperty
    a_gp: assert property (p_gp) else $error("timeout while connected");
endmodule : remap_asserts
bind modbus_register_remap remap_asserts #(.SUP_TIMEOUT_CYCLES(SUP_TIMEOUT_CYCLES)) u_chk (.*);
`default_nettype wire

// [tb/native_space_model.sv]
`timescale 1ns/1ps
`default_nettype none
module native_space_model (
    input  wire logic                  i_clk,
    input  wire logic                  i_req,
    input  wire remap_pkg::access_type i_acc,
    output logic                       o_ack = 1'b0,
    output logic [15:0]                o_rdata = 16'h0000);
    logic [15:0] mem [65536] = '{default: 16'h0000};
    logic [1:0]  cnt = 2'h0;
    // answer delay 0..3 cycles set by the low bits of the number
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack && cnt != i_acc.reg_num[1:0]) cnt <= cnt + 2'h1;
        else if (i_req && !o_ack) begin
            cnt <= 2'h0;
            o_ack <= 1'b1;
            if (!i_acc.write) o_rdata <= mem[i_acc.reg_num];
            else mem[i_acc.reg_num] <= i_acc.data; // one store per native number
        end
    end
endmodule : native_space_model
`default_nettype wire

// [tb/test_modbus_register_remap.sv]
`timescale 1ns/1ps
`default_nettype none
module test_modbus_register_remap;
    logic i_clk = 1'b0, i_reset = 1'b1, i_cfg_wr = 1'b0, i_cfg_done = 1'b0, i_commit = 1'b0;
    logic i_req = 1'b0, i_conn_open = 1'b0, i_conn_close = 1'b0, i_nat_ack, o_ready;
    logic i_cfg_sup_enable = 1'b1;
    logic [15:0] edge_regs [3] = '{16'h1388, 16'h13BA, 16'h13BB};
    logic o_rsp_valid, o_nat_req, o_sup_timeout, o_reset_request;
    logic [15:0] i_nat_rdata, o_rsp_data;
    logic [15:0] tm [5] = '{16'h0706, 16'h0707, 16'h080A, 16'h0816, 16'h080F};
    logic [31:0] seed = 32'h000180E4;
    remap_pkg::cfg_entry_type i_cfg_entry = '0;
    remap_pkg::access_type i_req_access = '0, o_nat_access;
    int miscompares = 0, n_tests = 0, tgt [50], shadow [65536];
    always #20 i_clk = ~i_clk;
    modbus_register_remap #(.SUP_TIMEOUT_CYCLES(20)) DUT (.i_clk, .i_reset, .i_cfg_wr,
        .i_cfg_entry, .i_cfg_sup_enable, .i_cfg_done, .i_commit, .i_req, .i_req_access,
        .i_nat_ack, .i_nat_rdata, .i_conn_open, .i_conn_close, .o_ready, .o_rsp_valid,
        .o_rsp_data, .o_nat_req, .o_nat_access, .o_sup_timeout, .o_reset_request);
    native_space_model u_nat (.i_clk, .i_req(o_nat_req), .i_acc(o_nat_access),
        .o_ack(i_nat_ack), .o_rdata(i_nat_rdata));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge i_clk) s = 1'b0;
        @(negedge i_clk);
    endtask : pulse
    task automatic acc(logic w, logic [15:0] r, logic [15:0] d);
        int t, e;
        t = r >= 5001 && r <= 5050 ? tgt[r - 5001] : r;
        e = w || t == 0 ? 0 : shadow[t];
        if (w && t != 0) shadow[t] = d;
        for (int k = 0; k < 40 && !o_ready; k++) @(negedge i_clk);
        chk("ready", 1'b1, o_ready);
        i_req_access = '{w, r, d};
        i_req = 1'b1;
        @(negedge i_clk) i_req = 1'b0;
        for (int k = 0; k < 40 && !o_rsp_valid; k++) @(negedge i_clk);
        chk("rsp_valid", 1'b1, o_rsp_valid);
        chk("rsp_data", e[15:0], o_rsp_data);
        @(negedge i_clk);
    endtask : acc
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #800000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (12) @(negedge i_clk);
        i_reset = 1'b0;
        foreach (tm[i]) begin
            tgt[i] = tm[i];
            i_cfg_entry = '{6'(i), tm[i]};
            pulse(i_cfg_wr);
        end
        pulse(i_cfg_done);
        i_cfg_entry = '{6'h05, 16'h0100};
        pulse(i_cfg_wr);
        for (int i = 0; i < 10; i++) acc(i < 5, 16'(5001 + i % 5), 16'(xs()));
        for (int i = 0; i < 99; i++) begin
            void'(xs());
            acc(seed[2], seed[3] ? 16'(5001 + seed[7:4]) : tm[seed[6:4] % 5], seed[31:16]);
        end
        foreach (edge_regs[i]) acc(1'b1, edge_regs[i], 16'(xs()));
        foreach (edge_regs[i]) acc(1'b0, edge_regs[i], 16'h0000);
        chk("sup_timeout", 1'b0, o_sup_timeout);
        pulse(i_conn_open);
        pulse(i_conn_close);
        repeat (18) @(negedge i_clk);
        chk("sup_timeout", 1'b0, o_sup_timeout);
        @(negedge i_clk);
        chk("sup_timeout", 1'b1, o_sup_timeout);
        pulse(i_conn_open);
        chk("sup_timeout", 1'b0, o_sup_timeout);
        chk("reset_request", 1'b0, o_reset_request);
        pulse(i_commit);
        chk("reset_request", 1'b1, o_reset_request);
        repeat (9) @(negedge i_clk); // master holds off while restarting
        i_reset = 1'b1;
        @(negedge i_clk) i_reset = 1'b0;
        chk("reset_request", 1'b0, o_reset_request);
        tgt = '{default: 0};
        tgt[49] = 16'h0100;
        i_cfg_sup_enable = 1'b0;
        i_cfg_entry = '{6'h31, 16'h0100};
        pulse(i_cfg_wr);
        pulse(i_cfg_done);
        acc(1'b0, 16'h1389, 16'h0000);
        for (int i = 0; i < 4; i++) acc(!i[0], i < 2 ? 16'h13BA : 16'h0100, 16'(xs()));
        pulse(i_conn_open);
        pulse(i_conn_close);
        repeat (22) @(negedge i_clk);
        chk("sup_timeout", 1'b0, o_sup_timeout);
        wrap_up();
    end
endmodule : test_modbus_register_remap
`default_nettype wire
